/* File: hdl/pwrseq_pkg.sv */
`default_nettype none

package pwrseq_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CORE_CLK_HZ = 50_000_000;
  localparam int unsigned OSC_HZ      = 10_000_000;
  // Core clocks per internal oscillator tick
  localparam int unsigned OSC_DIV     = CORE_CLK_HZ / OSC_HZ;
  localparam int unsigned CNT_W       = 22;

  // Wait lengths in oscillator ticks, chosen by a two-bit code
  // Calibration: 30 us, 300 us, 3 ms, 300 ms
  localparam logic [CNT_W-1:0] CAL_TICKS_0 = 22'h00012c;
  localparam logic [CNT_W-1:0] CAL_TICKS_1 = 22'h000bb8;
  localparam logic [CNT_W-1:0] CAL_TICKS_2 = 22'h007530;
  localparam logic [CNT_W-1:0] CAL_TICKS_3 = 22'h2dc6c0;
  // Settle: 20 us, 400 us, 2 ms, 200 ms
  localparam logic [CNT_W-1:0] VCO_TICKS_0 = 22'h0000c8;
  localparam logic [CNT_W-1:0] VCO_TICKS_1 = 22'h000fa0;
  localparam logic [CNT_W-1:0] VCO_TICKS_2 = 22'h004e20;
  localparam logic [CNT_W-1:0] VCO_TICKS_3 = 22'h1e8480;

  // Field positions of the wait selection byte
  localparam int unsigned CAL_SEL_LSB = 2;
  localparam int unsigned VCO_SEL_LSB = 0;
  localparam logic [7:0]  WAIT_SEL_RST = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [6:0] {
    ST_OFF    = 7'h01,
    ST_XTAL   = 7'h02,
    ST_CAL    = 7'h04,
    ST_VCO    = 7'h08,
    ST_LOCK   = 7'h10,
    ST_LOLCLR = 7'h20,
    ST_RUN    = 7'h40
  } seq_state_t;

  typedef struct packed {
    logic core_supply_good;
    logic output_supply_bank_a;
    logic power_down_n;
    logic xtal_amp_ok;
    logic pll_locked;
    logic pfd_tick;
  } sense_t;

  typedef struct packed {
    logic [1:0] cal_sel;
    logic [1:0] vco_sel;
  } wait_sel_t;

endpackage

`default_nettype wire

/* File: hdl/clock_gen_powerup_sequencer.sv */
`default_nettype none

module clock_gen_powerup_sequencer (
  // Clock and reset
  input  wire  logic               core_clk,
  input  wire  logic               reset_n,
  // Analog monitors and pins, asynchronous
  input  wire  pwrseq_pkg::sense_t sense,
  // Configuration
  input  wire  logic               xtal_used,
  input  wire  logic               soft_reset,
  input  wire  logic [7:0]         strap_cfg,
  input  wire  logic               lol_route_a,
  input  wire  logic               lol_route_b,
  // Status
  output logic                     dev_reset_n,
  output logic                     outputs_en,
  output logic                     i2c_en,
  output logic                     cfg_load,
  output logic [7:0]               wait_sel,
  output logic                     lock_loss_flag,
  output logic                     status_out_a,
  output logic                     status_out_b
);
  import pwrseq_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    sense_t          s1_ff;
    sense_t          s2_ff;
    logic            pdn_d_ff;
    logic            soft_d_ff;
    seq_state_t      st_ff;
    logic [2:0]      div_ff;
    logic            tick_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic            rst_n_ff;
    logic            oen_ff;
    logic            i2c_ff;
    logic            load_ff;
    logic [7:0]      sel_ff;
    logic            lol_ff;
    logic            sta_ff;
    logic            stb_ff;
  } regs_t;

  localparam regs_t REGS_RST = '{st_ff: ST_OFF, lol_ff: 1'h1, sta_ff: 1'h1,
                                 stb_ff: 1'h1, sel_ff: WAIT_SEL_RST, default: '0};

  regs_t q_ff;
  regs_t nxt_q;

  function automatic logic [CNT_W-1:0] cal_len(input logic [1:0] c);
    unique case (c)
      2'h0: cal_len = CAL_TICKS_0;
      2'h1: cal_len = CAL_TICKS_1;
      2'h2: cal_len = CAL_TICKS_2;
      default: cal_len = CAL_TICKS_3;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] vco_len(input logic [1:0] c);
    unique case (c)
      2'h0: vco_len = VCO_TICKS_0;
      2'h1: vco_len = VCO_TICKS_1;
      2'h2: vco_len = VCO_TICKS_2;
      default: vco_len = VCO_TICKS_3;
    endcase
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic      pwr_ok;
  logic      restart;
  logic      cnt_done;
  wait_sel_t ws;

  always_comb begin
    nxt_q        = q_ff;
    nxt_q.s1_ff  = sense;
    nxt_q.s2_ff  = q_ff.s1_ff; // Only the second stage is read by logic
    nxt_q.pdn_d_ff  = q_ff.s2_ff.power_down_n;
    nxt_q.soft_d_ff = soft_reset;
    nxt_q.load_ff   = 1'h0;
    ws.cal_sel = q_ff.sel_ff[CAL_SEL_LSB +: 2];
    ws.vco_sel = q_ff.sel_ff[VCO_SEL_LSB +: 2];
    // All supplies and the pin must be good to leave reset
    pwr_ok  = q_ff.s2_ff.core_supply_good & q_ff.s2_ff.output_supply_bank_a
              & q_ff.s2_ff.power_down_n;
    // Rising pin or soft reset bit restart the whole sequence
    restart = (q_ff.s2_ff.power_down_n & ~q_ff.pdn_d_ff)
              | (soft_reset & ~q_ff.soft_d_ff);
    cnt_done = q_ff.tick_ff && (q_ff.cnt_ff == '0);
    // Oscillator tick derived by division; counters step only on it
    nxt_q.tick_ff = (q_ff.div_ff == 3'(OSC_DIV - 1));
    nxt_q.div_ff  = nxt_q.tick_ff ? 3'h0 : q_ff.div_ff + 3'h1;
    nxt_q.i2c_ff  = q_ff.s2_ff.power_down_n;
    if (q_ff.tick_ff && q_ff.cnt_ff != '0) begin
      nxt_q.cnt_ff = q_ff.cnt_ff - CNT_W'(1'h1);
    end
    if (!pwr_ok || restart) begin
      // Device reset and outputs held off, lock-loss flag set, divider restarted; straps reload on leaving ST_OFF
      nxt_q.st_ff    = ST_OFF;
      nxt_q.rst_n_ff = 1'h0;
      nxt_q.oen_ff   = 1'h0;
      nxt_q.lol_ff   = 1'h1;
      nxt_q.div_ff   = 3'h0;
      nxt_q.tick_ff  = 1'h0;
    end else begin
      unique case (q_ff.st_ff)
        ST_OFF: begin
          // Release aligned to an oscillator edge so waits start from zero
          if (q_ff.tick_ff) begin
            nxt_q.rst_n_ff = 1'h1;
            nxt_q.load_ff  = 1'h1;
            nxt_q.sel_ff   = strap_cfg;
            nxt_q.st_ff    = ST_XTAL;
          end
        end
        ST_XTAL: begin
          // Hold while a used crystal's swing is too small
          if (!xtal_used || q_ff.s2_ff.xtal_amp_ok) begin
            nxt_q.st_ff  = ST_CAL;
            nxt_q.cnt_ff = cal_len(ws.cal_sel);
          end
        end
        ST_CAL: begin
          if (cnt_done) begin
            nxt_q.st_ff  = ST_VCO;
            nxt_q.cnt_ff = vco_len(ws.vco_sel);
          end
        end
        ST_VCO: begin
          if (cnt_done) begin
            nxt_q.oen_ff = 1'h1;
            nxt_q.st_ff  = ST_LOCK;
          end
        end
        ST_LOCK: begin
          if (q_ff.s2_ff.pll_locked) begin
            nxt_q.st_ff = ST_LOLCLR;
          end
        end
        ST_LOLCLR: begin
          // One phase-detector cycle after lock, then clear the flag
          if (q_ff.s2_ff.pfd_tick) begin
            nxt_q.lol_ff = 1'h0;
            nxt_q.st_ff  = ST_RUN;
          end
        end
        ST_RUN: begin
          if (!q_ff.s2_ff.pll_locked) begin
            nxt_q.lol_ff = 1'h1;
            nxt_q.st_ff  = ST_LOCK;
          end
        end
        default: nxt_q.st_ff = ST_OFF;
      endcase
    end
    // Status pins carry the flag only when routed
    nxt_q.sta_ff = lol_route_a ? nxt_q.lol_ff : 1'h1;
    nxt_q.stb_ff = lol_route_b ? nxt_q.lol_ff : 1'h1;
  end

  // Single state register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q_ff <= REGS_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign dev_reset_n    = q_ff.rst_n_ff;
  assign outputs_en     = q_ff.oen_ff;
  assign i2c_en         = q_ff.i2c_ff;
  assign cfg_load       = q_ff.load_ff;
  assign wait_sel       = q_ff.sel_ff;
  assign lock_loss_flag = q_ff.lol_ff;
  assign status_out_a   = q_ff.sta_ff;
  assign status_out_b   = q_ff.stb_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_pwr_hold_off: assert property (!pwr_ok |=> !dev_reset_n)
    else $error("reset released without power good");
  a_pin_low_off: assert property (!q_ff.s2_ff.power_down_n |=> !outputs_en && !i2c_en)
    else $error("device active while pin low");
  a_xtal_pause: assert property (q_ff.st_ff == ST_XTAL && xtal_used && !q_ff.s2_ff.xtal_amp_ok
                                  && pwr_ok && !restart |=> q_ff.st_ff == ST_XTAL)
    else $error("sequence left crystal wait early");
  a_cal_load: assert property (q_ff.st_ff == ST_XTAL && nxt_q.st_ff == ST_CAL
                                |=> q_ff.cnt_ff == cal_len($past(ws.cal_sel)))
    else $error("calibration count wrong");
  a_vco_load: assert property (q_ff.st_ff == ST_CAL && nxt_q.st_ff == ST_VCO
                                |=> q_ff.cnt_ff == vco_len($past(ws.vco_sel)))
    else $error("settle count wrong");
  a_out_enable: assert property (q_ff.st_ff == ST_VCO && cnt_done && pwr_ok && !restart
                                  |=> outputs_en)
    else $error("outputs not enabled after waits");
  a_lol_clear: assert property (q_ff.st_ff == ST_LOLCLR && q_ff.s2_ff.pfd_tick && pwr_ok
                                 && !restart |=> !lock_loss_flag)
    else $error("lock loss flag not cleared");
  // Held off for at least two edges, so the divider restarts from a clean phase
  sequence held_off_two;
    !dev_reset_n ##1 !dev_reset_n;
  endsequence

  a_restart_seq: assert property (restart |=> held_off_two)
    else $error("restart did not reset");
  a_rel_on_tick: assert property ($rose(dev_reset_n) |-> $past(q_ff.tick_ff))
    else $error("release not on oscillator edge");
  // Outputs may only come on at the end of the settle wait
  a_out_order: assert property ($rose(outputs_en) |-> $past(q_ff.st_ff) == ST_VCO)
    else $error("outputs enabled out of sequence");

endmodule

`default_nettype wire

/* File: tb/pdn_host.sv */
`default_nettype none

module pdn_host (
  // Clock and request
  input  wire logic core_clk,
  input  wire logic enable_req,
  // Power-down pin, driven low from time zero
  output logic      power_down_n = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;

  // Host sequencer keeps the device off until its own supplies are ready
  always @(posedge core_clk) power_down_n <= enable_req;
endmodule

`default_nettype wire

/* File: tb/tb.sv */
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pwrseq_pkg::*;

  // Oscillator ticks of both waits, each wait one tick past its load
  localparam int SHORT_TICKS   = CAL_TICKS_0 + VCO_TICKS_0 + 2;
  localparam int PROFILE_TICKS = CAL_TICKS_1 + VCO_TICKS_1 + 2;

  logic       core_clk = 0, reset_n = 0, enable_req = 0, core_ok = 0, bank_ok = 0;
  logic       amp_ok = 0, locked = 0, pfd = 0, xtal_used = 0, soft_reset = 0, route_a = 0;
  logic [7:0] strap = 8'h00, wait_sel;
  logic       power_down_n, dev_reset_n, outputs_en, i2c_en, cfg_load;
  logic       lock_loss_flag, status_out_a, status_out_b;
  sense_t     sense;
  int         mismatches = 0, checks = 0, n;
  logic [7:0] exp_q[$];

  assign sense = '{core_ok, bank_ok, power_down_n, amp_ok, locked, pfd};

  // 50 MHz core clock
  initial forever #10 core_clk = ~core_clk;

  pdn_host i_pdn_host (.core_clk(core_clk), .enable_req(enable_req),
                       .power_down_n(power_down_n));

  clock_gen_powerup_sequencer i_clock_gen_powerup_sequencer (
    .core_clk(core_clk), .reset_n(reset_n), .sense(sense), .xtal_used(xtal_used),
    .soft_reset(soft_reset), .strap_cfg(strap), .lol_route_a(route_a),
    .lol_route_b(~route_a), .dev_reset_n(dev_reset_n), .outputs_en(outputs_en),
    .i2c_en(i2c_en), .cfg_load(cfg_load), .wait_sel(wait_sel),
    .lock_loss_flag(lock_loss_flag), .status_out_a(status_out_a),
    .status_out_b(status_out_b));

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Outputs are read right after an edge, so they show the settled previous cycle
  task automatic step(int k);
    repeat (k) @(posedge core_clk);
  endtask

  // Start by pin rise, soft reset or supply return, then walk the whole sequence
  task automatic power_up(int mode, logic [3:0] code, int ticks);
    logic [7:0] s;
    int         lim;
    lim = ticks * OSC_DIV;
    s = {4'($urandom), code}; // Upper strap bits are free; the low nibble picks both waits
    @(posedge core_clk);
    strap <= s;
    locked <= 0;
    amp_ok <= 0;
    route_a <= 1'($urandom);
    xtal_used <= (mode == 0);
    exp_q.push_back(s);
    case (mode)
      0: enable_req <= 1;
      1: soft_reset <= 1;
      default: begin
        core_ok <= 1;
        bank_ok <= 1;
      end
    endcase
    step(1);
    soft_reset <= 0;
    for (n = 0; n < 40 && cfg_load !== 1'h1; n++) @(posedge core_clk);
    check("release", 8'(n < 40), 8'h01);
    check("outputs_en", outputs_en, 8'h00);
    if (mode == 0) begin
      step(3000);
      check("outputs_en", outputs_en, 8'h00);
      amp_ok <= 1;
    end
    for (n = 0; n < lim + 20 && outputs_en !== 1'h1; n++) @(posedge core_clk);
    // Up to one tick of slack, since the crystal wait ends at any oscillator phase
    check("wait_len", 8'(n inside {[lim:lim + 4]}), 8'h01);
    check("lock_loss_flag", lock_loss_flag, 8'h01);
    locked <= 1;
    step(10);
    check("lock_loss_flag", lock_loss_flag, 8'h01);
    pfd <= 1;
    step(1);
    pfd <= 0;
    step(6);
    check("lock_loss_flag", lock_loss_flag, 8'h00);
    check("status_out_a", status_out_a, 8'(!route_a));
    check("status_out_b", status_out_b, 8'(route_a));
    check("i2c_en", i2c_en, 8'h01);
  endtask

  // Each strap load must carry the value noted by the driver
  always @(posedge core_clk) begin
    if (cfg_load === 1'h1) begin
      if (exp_q.size() == 0) check("cfg_load", 8'h01, 8'h00);
      else check("wait_sel", wait_sel, exp_q.pop_front());
    end
  end

  // Main sequence
  initial begin
    void'($urandom(31293));
    step(6);
    reset_n <= 1;
    step(1);
    core_ok <= 1;
    bank_ok <= 1;
    step(20);
    check("dev_reset_n", dev_reset_n, 8'h00);
    check("i2c_en", i2c_en, 8'h00);
    power_up(0, 4'h0, SHORT_TICKS);
    enable_req <= 0;
    step(8);
    check("dev_reset_n", dev_reset_n, 8'h00);
    check("outputs_en", outputs_en, 8'h00);
    check("i2c_en", i2c_en, 8'h00);
    power_up(0, 4'h0, SHORT_TICKS);
    power_up(1, 4'h0, SHORT_TICKS);
    // Recommended clock-generator profile: both waits on code 1
    power_up(1, 4'h5, PROFILE_TICKS);
    if ($urandom % 2) core_ok <= 0;
    else bank_ok <= 0;
    step(8);
    check("dev_reset_n", dev_reset_n, 8'h00);
    check("outputs_en", outputs_en, 8'h00);
    power_up(2, 4'h0, SHORT_TICKS);
    check("pending", 8'(exp_q.size()), 8'h00);
    wrap_up();
  end

  // Watchdog sized well beyond four short sequences and one long profile
  initial begin
    step(75000);
    mismatches++;
    wrap_up();
  end
endmodule

`default_nettype wire
